// >>> hw/hdlc_fifo_pkg.sv
// constants for the per-framer hdlc fifo, status and interrupt block
// assumes an 8-bit host register port and a 13-bit framer address space
package hdlc_fifo_pkg;

  // ****************************************
  // fifo geometry
  // ****************************************
  localparam int unsigned DEPTH = 64;
  localparam int unsigned PTR_W = 7;
  localparam logic [6:0] DEPTH_CNT = 7'h40;

  // ****************************************
  // address map, offsets within one framer
  // ****************************************
  localparam int unsigned ADDR_W = 13;
  localparam logic [12:0] FRAMER_STRIDE = 13'h200;
  localparam logic [8:0] RX_CTL_OFF = 9'h087;
  localparam logic [8:0] RX_LS_OFF = 9'h094;
  localparam logic [8:0] RX_IM_OFF = 9'h0a4;
  localparam logic [8:0] RX_RT_OFF = 9'h0b4;
  localparam logic [8:0] RX_AVAIL_OFF = 9'h0b5;
  localparam logic [8:0] RX_DATA_OFF = 9'h0b6;
  localparam logic [8:0] TX_CTL_OFF = 9'h187;
  localparam logic [8:0] TX_LS_OFF = 9'h191;
  localparam logic [8:0] TX_IM_OFF = 9'h1a1;
  localparam logic [8:0] TX_RT_OFF = 9'h1b1;
  localparam logic [8:0] TX_SPACE_OFF = 9'h1b3;
  localparam logic [8:0] TX_DATA_OFF = 9'h1b4;
  localparam logic [8:0] TX_LAST_OFF = 9'h1b5;

  // ****************************************
  // status bit positions
  // ****************************************
  localparam int unsigned RX_EMPTY_BIT = 0;
  localparam int unsigned RX_PKT_END_BIT = 0;
  localparam int unsigned RX_HWM_BIT = 1;
  localparam int unsigned RX_OVR_BIT = 5;
  localparam int unsigned TX_EMPTY_BIT = 0;
  localparam int unsigned TX_LWM_BIT = 1;
  localparam int unsigned AVAIL_MORE_BIT = 7;

  // ****************************************
  // values after reset
  // ****************************************
  localparam logic [6:0] RX_HWM_RESET = 7'h30;
  localparam logic [6:0] TX_LWM_RESET = 7'h10;
  localparam logic [7:0] MASK_RESET = 8'h00;
endpackage

// >>> hw/hdlc_fifo_status_interrupt.sv
// host-side receive/transmit hdlc fifos with watermarks, status and interrupt
// assumes the hdlc engine and host port are synchronous to clk
//
// Summary of operation
// RULE1 - rx high-watermark flag sits in real-time rx status bit 1
// RULE2 - that flag is live: high only while rx fill exceeds watermark
// RULE3 - tx low-watermark flag is live: high while tx fill below watermark
// RULE4 - tx low-watermark condition can raise the interrupt when unmasked
// RULE5 - rx overrun drops the packet in progress and empties the rx fifo
// RULE6 - overrun shows in real-time rx status and latched rx status bit 5
// RULE7 - bytes-available low 7 bits count readable rx bytes, 0 to 64
// RULE8 - that count stops at the first message boundary
// RULE9 - its msb is 1 when the counted bytes belong to an unfinished packet
// RULE10 - host checks status after reading out a finished packet
// RULE11 - latched bits hold until cleared and reset only on a new event
// RULE12 - writing 1 clears a latched bit; real-time bits ignore writes
// RULE13 - real-time bits show the present condition without history
// RULE14 - every latched rx and tx event has its own interrupt mask bit
// RULE15 - an unmasked event pulls the active-low interrupt output low
// RULE16 - interrupt releases once the host reads the causing status bit
// RULE17 - tx space-available gives bytes writable without overflow
// RULE18 - tx space-available is sampled once per read and held stable
// RULE19 - fifo control registers hold the watermark thresholds
// RULE20 - framer n registers sit at framer 1 address plus (n-1)*200h
// RULE21 - each direction has a 64-byte fifo between engine and host
// RULE22 - watermarks are the low 7 bits of the fifo control registers
//
// The register offsets and the plain strobed port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none

module hdlc_fifo_status_interrupt #(
  parameter logic [3:0] FRAMER_INDEX = 4'h1
) (
  input  wire logic        clk,       // system clock
  input  wire logic        rst,       // synchronous reset, active high
  input  wire logic [12:0] addr,      // host register address
  input  wire logic [7:0]  wdata,     // host write data
  input  wire logic        wr,        // host write strobe
  input  wire logic        rd,        // host read strobe
  output logic      [7:0]  rdata,     // read data, cycle after rd
  output logic             irq_out_n, // interrupt, active low
  input  wire logic        rx_wr,     // engine pushes a received byte
  input  wire logic [7:0]  rx_byte,   // received byte
  input  wire logic        rx_eop,    // byte closes its packet
  input  wire logic        tx_rd,     // engine takes the head tx byte
  output logic      [7:0]  tx_byte,   // head tx byte
  output logic             tx_last,   // head byte closes its message
  output logic             tx_valid   // tx fifo holds a byte
);

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    logic [63:0][8:0] rx_mem;
    logic [6:0]       rx_wp;
    logic [6:0]       rx_rp;
    logic             rx_drop;
    logic             rx_hwm_prev;
    logic [6:0]       rx_hwm;
    logic [7:0]       rx_ls;
    logic [7:0]       rx_im;
    logic [7:0]       rx_pend;
    logic [63:0][8:0] tx_mem;
    logic [6:0]       tx_wp;
    logic [6:0]       tx_rp;
    logic             tx_lwm_prev;
    logic             tx_empty_prev;
    logic [6:0]       tx_lwm;
    logic [7:0]       tx_ls;
    logic [7:0]       tx_im;
    logic [7:0]       tx_pend;
    logic [7:0]       rdata;
    logic             irq_n;
    logic [7:0]       tx_byte;
    logic             tx_last;
    logic             tx_valid;
  } state_t;

  state_t q;
  state_t d;

  // ****************************************
  // address decode
  // ****************************************
  // each framer copy answers only inside its own 200h window
  localparam logic [12:0] BASE = 13'(FRAMER_INDEX - 4'h1) * hdlc_fifo_pkg::FRAMER_STRIDE; // RULE20

  logic [12:0] rel;
  logic        sel;
  logic [8:0]  off;

  assign rel = addr - BASE;
  assign sel = rel < hdlc_fifo_pkg::FRAMER_STRIDE; // RULE20
  assign off = rel[8:0];

  // ****************************************
  // levels and live flags
  // ****************************************
  logic [6:0] rx_level;
  logic [6:0] tx_level;
  logic [6:0] tx_space;
  logic       rx_hwm_now;
  logic       tx_lwm_now;
  logic       tx_empty_now;
  logic [7:0] rx_rt;
  logic [7:0] tx_rt;

  assign rx_level = q.rx_wp - q.rx_rp;
  assign tx_level = q.tx_wp - q.tx_rp;
  assign tx_space = hdlc_fifo_pkg::DEPTH_CNT - tx_level; // RULE17
  assign rx_hwm_now = rx_level > q.rx_hwm; // RULE1 RULE2
  assign tx_lwm_now = tx_level < q.tx_lwm; // RULE3
  assign tx_empty_now = tx_level == 7'h00;

  // real-time views are rebuilt each cycle, nothing remembered
  always_comb begin
    rx_rt = 8'h00;
    rx_rt[hdlc_fifo_pkg::RX_EMPTY_BIT] = rx_level == 7'h00; // RULE13
    rx_rt[hdlc_fifo_pkg::RX_HWM_BIT] = rx_hwm_now; // RULE1
    rx_rt[hdlc_fifo_pkg::RX_OVR_BIT] = q.rx_drop; // RULE6
    tx_rt = 8'h00;
    tx_rt[hdlc_fifo_pkg::TX_EMPTY_BIT] = tx_empty_now; // RULE13
    tx_rt[hdlc_fifo_pkg::TX_LWM_BIT] = tx_lwm_now; // RULE3
  end

  // ****************************************
  // bytes available up to the first boundary
  // ****************************************
  logic [63:0] eop_at;

  genvar gi;
  generate
    for (gi = 0; gi < hdlc_fifo_pkg::DEPTH; gi++) begin : g_eop
      assign eop_at[gi] = q.rx_mem[q.rx_rp[5:0] + 6'(gi)][8] && (7'(gi) < rx_level);
    end
  endgenerate

  logic [6:0] seg_cnt;
  logic       seg_end;
  logic [7:0] rx_avail;

  // scan from the head; stop counting after the first end-of-packet byte
  always_comb begin
    seg_cnt = 7'h00;
    seg_end = 1'b0;
    for (int i = 0; i < hdlc_fifo_pkg::DEPTH; i++) begin
      if (!seg_end && (7'(i) < rx_level)) begin
        seg_cnt = seg_cnt + 7'h01; // RULE7
        seg_end = eop_at[i]; // RULE8
      end
    end
    rx_avail = {1'b0, seg_cnt};
    rx_avail[hdlc_fifo_pkg::AVAIL_MORE_BIT] = !seg_end && (rx_level != 7'h00); // RULE9
  end

  // ****************************************
  // next state
  // ****************************************
  logic       hw_rd;
  logic       hw_wr;
  logic [7:0] rx_set;
  logic [7:0] tx_set;
  logic [7:0] rx_clr;
  logic [7:0] tx_clr;
  logic [7:0] rd_val;

  always_comb begin
    d = q;
    hw_rd = rd && sel;
    hw_wr = wr && sel;
    rx_set = 8'h00;
    tx_set = 8'h00;
    rx_clr = 8'h00;
    tx_clr = 8'h00;
    rd_val = 8'h00;

    // host read mux, sampled at the strobe so the value holds for the cycle
    if (hw_rd) begin
      case (off)
        hdlc_fifo_pkg::RX_CTL_OFF: begin
          rd_val = {1'b0, q.rx_hwm};
        end
        hdlc_fifo_pkg::RX_LS_OFF: begin
          rd_val = q.rx_ls;
        end
        hdlc_fifo_pkg::RX_IM_OFF: begin
          rd_val = q.rx_im;
        end
        hdlc_fifo_pkg::RX_RT_OFF: begin
          rd_val = rx_rt;
        end
        hdlc_fifo_pkg::RX_AVAIL_OFF: begin
          rd_val = rx_avail; // RULE7
        end
        hdlc_fifo_pkg::RX_DATA_OFF: begin
          if (rx_level != 7'h00) begin
            rd_val = q.rx_mem[q.rx_rp[5:0]][7:0];
            d.rx_rp = q.rx_rp + 7'h01;
          end
        end
        hdlc_fifo_pkg::TX_CTL_OFF: begin
          rd_val = {1'b0, q.tx_lwm};
        end
        hdlc_fifo_pkg::TX_LS_OFF: begin
          rd_val = q.tx_ls;
        end
        hdlc_fifo_pkg::TX_IM_OFF: begin
          rd_val = q.tx_im;
        end
        hdlc_fifo_pkg::TX_RT_OFF: begin
          rd_val = tx_rt;
        end
        hdlc_fifo_pkg::TX_SPACE_OFF: begin
          rd_val = {1'b0, tx_space}; // RULE18
        end
        default: begin
          rd_val = 8'h00;
        end
      endcase
    end
    d.rdata = rd_val;

    // host writes; status registers only clear, real-time ones ignore it
    if (hw_wr) begin
      case (off)
        hdlc_fifo_pkg::RX_CTL_OFF: begin
          d.rx_hwm = wdata[6:0]; // RULE19 RULE22
        end
        hdlc_fifo_pkg::RX_LS_OFF: begin
          rx_clr = wdata; // RULE12
        end
        hdlc_fifo_pkg::RX_IM_OFF: begin
          d.rx_im = wdata; // RULE14
        end
        hdlc_fifo_pkg::TX_CTL_OFF: begin
          d.tx_lwm = wdata[6:0]; // RULE19 RULE22
        end
        hdlc_fifo_pkg::TX_LS_OFF: begin
          tx_clr = wdata; // RULE12
        end
        hdlc_fifo_pkg::TX_IM_OFF: begin
          d.tx_im = wdata; // RULE14
        end
        hdlc_fifo_pkg::TX_DATA_OFF, hdlc_fifo_pkg::TX_LAST_OFF: begin
          // writes beyond the free space are dropped, never wrap
          if (tx_level != hdlc_fifo_pkg::DEPTH_CNT) begin // RULE17
            d.tx_mem[q.tx_wp[5:0]] = {off == hdlc_fifo_pkg::TX_LAST_OFF, wdata};
            d.tx_wp = q.tx_wp + 7'h01;
          end
        end
        default: begin
        end
      endcase
    end

    // receive side from the engine
    if (rx_wr) begin
      if (q.rx_drop) begin
        // discard the rest of the overrun packet up to its end
        d.rx_drop = !rx_eop; // RULE5
      end else if (rx_level == hdlc_fifo_pkg::DEPTH_CNT) begin
        d.rx_rp = q.rx_wp; // RULE5
        d.rx_drop = !rx_eop; // RULE5
        rx_set[hdlc_fifo_pkg::RX_OVR_BIT] = 1'b1; // RULE6
      end else begin
        d.rx_mem[q.rx_wp[5:0]] = {rx_eop, rx_byte}; // RULE21
        d.rx_wp = q.rx_wp + 7'h01;
        rx_set[hdlc_fifo_pkg::RX_PKT_END_BIT] = rx_eop;
      end
    end

    // transmit side to the engine
    if (tx_rd && q.tx_valid) begin
      d.tx_rp = q.tx_rp + 7'h01;
    end

    // latched events on the rising edge of the live conditions
    d.rx_hwm_prev = rx_hwm_now;
    d.tx_lwm_prev = tx_lwm_now;
    d.tx_empty_prev = tx_empty_now;
    rx_set[hdlc_fifo_pkg::RX_HWM_BIT] = rx_hwm_now && !q.rx_hwm_prev;
    tx_set[hdlc_fifo_pkg::TX_LWM_BIT] = tx_lwm_now && !q.tx_lwm_prev; // RULE4
    tx_set[hdlc_fifo_pkg::TX_EMPTY_BIT] = tx_empty_now && !q.tx_empty_prev;

    // a new event beats a clear in the same cycle
    d.rx_ls = (q.rx_ls & ~rx_clr) | rx_set; // RULE11 RULE12
    d.tx_ls = (q.tx_ls & ~tx_clr) | tx_set; // RULE11 RULE12

    // pending causes end when the host reads the status register
    d.rx_pend = q.rx_pend;
    d.tx_pend = q.tx_pend;
    if (hw_rd && (off == hdlc_fifo_pkg::RX_LS_OFF)) begin
      d.rx_pend = 8'h00; // RULE16
    end
    if (hw_rd && (off == hdlc_fifo_pkg::TX_LS_OFF)) begin
      d.tx_pend = 8'h00; // RULE16
    end
    d.rx_pend = d.rx_pend | (rx_set & q.rx_im); // RULE14 RULE15
    d.tx_pend = d.tx_pend | (tx_set & q.tx_im); // RULE4 RULE14
    // unmasking later does not revive an old cause; masking drops it at once
    d.irq_n = !(|(d.rx_pend & d.rx_im) || |(d.tx_pend & d.tx_im)); // RULE15 RULE16

    // head of the tx fifo is presented registered
    d.tx_valid = d.tx_wp != d.tx_rp;
    d.tx_byte = d.tx_mem[d.tx_rp[5:0]][7:0];
    d.tx_last = d.tx_mem[d.tx_rp[5:0]][8] && d.tx_valid;
  end

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge clk) begin
    if (rst) begin
      q <= '0;
      q.rx_hwm <= hdlc_fifo_pkg::RX_HWM_RESET;
      q.tx_lwm <= hdlc_fifo_pkg::TX_LWM_RESET;
      q.rx_im <= hdlc_fifo_pkg::MASK_RESET;
      q.tx_im <= hdlc_fifo_pkg::MASK_RESET;
      q.irq_n <= 1'b1;
      q.tx_empty_prev <= 1'b1;
      q.tx_lwm_prev <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign rdata = q.rdata;
  assign irq_out_n = q.irq_n;
  assign tx_byte = q.tx_byte;
  assign tx_last = q.tx_last;
  assign tx_valid = q.tx_valid;

endmodule // hdlc_fifo_status_interrupt

`default_nettype wire

// >>> verification/hdlc_engine_model.sv
// engine-side model: pushes rx bytes on request, drains tx with random stalls
// assumes the bench calls push and raises drain
`timescale 1ns/1ps
`default_nettype none
module hdlc_engine_model (
  input  wire logic       clk,     // clock
  input  wire logic       rst,     // reset
  input  wire logic       drain,   // take tx bytes
  output logic            rx_wr,   // rx strobe
  output logic      [7:0] rx_byte, // rx byte
  output logic            rx_eop,  // rx end
  output logic            tx_rd,   // tx take
  input  wire logic [7:0] tx_byte, // tx head
  input  wire logic       tx_last, // tx end
  input  wire logic       tx_valid // tx valid
);
  logic [8:0] got[$];
  initial begin
    rx_wr = 1'b0;
    rx_byte = 8'h00;
    rx_eop = 1'b0;
  end
  task automatic push(input logic [7:0] b, input logic e);
    @(posedge clk);
    rx_wr <= 1'b1;
    rx_byte <= b;
    rx_eop <= e;
    @(posedge clk);
    rx_wr <= 1'b0;
    rx_eop <= 1'b0;
    // idle byte lane must not look like the stale value
    rx_byte <= ~b;
  endtask
  always @(posedge clk) begin
    if (!rst && tx_rd && tx_valid) got.push_back({tx_last, tx_byte});
    tx_rd <= drain && !rst && ($urandom % 4 != 0);
  end
endmodule // hdlc_engine_model
`default_nettype wire

// >>> verification/hdlc_fifo_status_interrupt_properties.sv
// port assertions for the hdlc fifo, status and interrupt block
// bound onto the design top from the bench top file
`timescale 1ns/1ps
`default_nettype none
module hdlc_fifo_props #(
  parameter logic [3:0] FRAMER_INDEX = 4'h1
) (
  input wire logic        clk,       // clock
  input wire logic        rst,       // reset
  input wire logic [12:0] addr,      // address
  input wire logic [7:0]  wdata,     // wr data
  input wire logic        wr,        // write
  input wire logic        rd,        // read
  input wire logic [7:0]  rdata,     // rd data
  input wire logic        irq_out_n, // irq
  input wire logic        rx_wr,     // rx push
  input wire logic [7:0]  rx_byte,   // rx byte
  input wire logic        rx_eop,    // rx end
  input wire logic        tx_rd,     // tx take
  input wire logic [7:0]  tx_byte,   // tx head
  input wire logic        tx_last,   // tx end
  input wire logic        tx_valid   // tx valid
);
  localparam logic [12:0] BASE = {FRAMER_INDEX - 4'h1, 9'h000};
  // ages since the last input that may move the interrupt; kept loose for the event lag
  logic [2:0] ev_age_q;
  logic [2:0] rd_age_q;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  always_ff @(posedge clk) begin
    ev_age_q <= (rst || rx_wr || tx_rd || wr) ? 3'h0 : ev_age_q + {2'h0, ev_age_q != 3'h7};
    rd_age_q <= (rst || rd || wr) ? 3'h0 : rd_age_q + {2'h0, rd_age_q != 3'h7};
  end
  a_rdata_idle: assert property (!$past(rd) |-> rdata == 8'h00)
    else $error("read data not idle");
  a_reset_quiet: assert property ($fell(rst) |-> irq_out_n && !tx_valid)
    else $error("outputs busy after reset");
  a_tx_push_head: assert property (wr && !tx_valid && addr == BASE + {4'h0, hdlc_fifo_pkg::TX_DATA_OFF}
    |=> tx_valid && tx_byte == $past(wdata) && !tx_last)
    else $error("tx head not loaded");
  a_tx_space_full: assert property (rd && !tx_valid && addr == BASE + {4'h0, hdlc_fifo_pkg::TX_SPACE_OFF}
    |=> rdata == 8'h40)
    else $error("empty tx space wrong");
  a_window_other: assert property (rd && addr[12:9] != FRAMER_INDEX - 4'h1 |=> rdata == 8'h00)
    else $error("foreign framer read answered");
  a_irq_fall_cause: assert property ($fell(irq_out_n) |-> ev_age_q < 3'h5)
    else $error("interrupt without event");
  a_irq_rise_cause: assert property ($rose(irq_out_n) |-> rd_age_q < 3'h3)
    else $error("interrupt released without access");
  a_tx_head_hold: assert property (tx_valid && !tx_rd |=> tx_valid && $stable(tx_byte) && $stable(tx_last))
    else $error("tx head moved untaken");
endmodule // hdlc_fifo_props
`default_nettype wire

// >>> verification/hdlc_fifo_status_interrupt_test.sv
// self-checking bench for the hdlc fifo, status and interrupt block
// host port driven here; the engine model feeds rx and drains tx
`timescale 1ns/1ps
`default_nettype none
module hdlc_fifo_status_interrupt_test;
  localparam logic [8:0] RLS = hdlc_fifo_pkg::RX_LS_OFF;
  localparam logic [8:0] RDAT = hdlc_fifo_pkg::RX_DATA_OFF;
  localparam logic [8:0] RAV = hdlc_fifo_pkg::RX_AVAIL_OFF;
  localparam logic [8:0] RRT = hdlc_fifo_pkg::RX_RT_OFF;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [12:0] addr = 13'h0000;
  logic [7:0]  wdata = 8'h00;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic        drain = 1'b0;
  logic [3:0]  win = 4'h1;
  logic [7:0]  rdata, tx_byte, rx_byte;
  logic        irq_out_n, rx_wr, rx_eop, tx_rd, tx_last, tx_valid;
  logic [7:0]  q[$];
  int          errors = 0;
  int          num_checks = 0;
  int          n, m;
  always #5 clk = ~clk;
  hdlc_fifo_status_interrupt #(.FRAMER_INDEX(4'h2)) i_dut (
    .clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .irq_out_n(irq_out_n), .rx_wr(rx_wr), .rx_byte(rx_byte), .rx_eop(rx_eop), .tx_rd(tx_rd),
    .tx_byte(tx_byte), .tx_last(tx_last), .tx_valid(tx_valid));
  hdlc_engine_model i_eng (
    .clk(clk), .rst(rst), .drain(drain), .rx_wr(rx_wr), .rx_byte(rx_byte), .rx_eop(rx_eop),
    .tx_rd(tx_rd), .tx_byte(tx_byte), .tx_last(tx_last), .tx_valid(tx_valid));
  // ****************************************
  // host tasks
  // ****************************************
  task automatic chk(input logic [8:0] got, input logic [8:0] exp);
    num_checks++;
    if (got !== exp) begin
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      errors++;
    end
  endtask
  task automatic wr_reg(input logic [8:0] off, input logic [7:0] d);
    @(posedge clk);
    addr <= {win, off};
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_chk(input logic [8:0] off, input logic [7:0] exp);
    @(posedge clk);
    addr <= {win, off};
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk({1'b0, rdata}, {1'b0, exp});
  endtask
  task automatic pop(input int k);
    for (int i = 0; i < k; i++) rd_chk(RDAT, q.pop_front());
  endtask
  task automatic irq_is(input logic v);
    repeat (3) @(posedge clk);
    #1 chk({8'h00, irq_out_n}, {8'h00, v});
  endtask
  task automatic tx_run(input int k);
    int e;
    logic [8:0] d[$];
    e = (k > 64) ? 64 : k;
    i_eng.got.delete();
    for (int i = 0; i < k; i++) begin
      d.push_back({i == k - 1, 8'($urandom)});
      wr_reg(i == k - 1 ? hdlc_fifo_pkg::TX_LAST_OFF : hdlc_fifo_pkg::TX_DATA_OFF, d[i][7:0]);
    end
    rd_chk(hdlc_fifo_pkg::TX_SPACE_OFF, 8'(64 - e));
    rd_chk(hdlc_fifo_pkg::TX_RT_OFF, 8'h00);
    drain <= 1'b1;
    for (int t = 0; t < 3000 && i_eng.got.size() < e; t++) @(posedge clk);
    drain <= 1'b0;
    if (i_eng.got.size() < e) begin
      errors++;
      tally_and_finish();
    end
    repeat (4) @(posedge clk);
    #1;
    for (int i = 0; i < e; i++) chk(i_eng.got[i], d[i]);
    chk({8'h00, irq_out_n}, 9'h000);
    rd_chk(hdlc_fifo_pkg::TX_LS_OFF, 8'h03);
    rd_chk(hdlc_fifo_pkg::TX_RT_OFF, 8'h03);
    wr_reg(hdlc_fifo_pkg::TX_LS_OFF, 8'h03);
    irq_is(1'b1);
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // ****************************************
  // sequence
  // ****************************************
  initial begin
    void'($urandom(61));
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    rd_chk(hdlc_fifo_pkg::RX_CTL_OFF, 8'h30);
    rd_chk(hdlc_fifo_pkg::TX_CTL_OFF, 8'h10);
    rd_chk(hdlc_fifo_pkg::TX_SPACE_OFF, 8'h40);
    rd_chk(RAV, 8'h00);
    rd_chk(9'h000, 8'h00);
    wr_reg(RRT, 8'hff);
    rd_chk(RRT, 8'h01);
    $display("reset values done");
    n = 1 + $urandom % 20;
    m = 1 + $urandom % 10;
    for (int i = 0; i < n + m; i++) begin
      q.push_back(8'($urandom));
      i_eng.push(q[i], i == n - 1);
    end
    rd_chk(RLS, 8'h01);
    wr_reg(RLS, 8'h01);
    rd_chk(RLS, 8'h00);
    rd_chk(RAV, 8'(n));
    pop(n);
    rd_chk(RAV, 8'h80 | 8'(m));
    q.push_back(8'h5a);
    i_eng.push(8'h5a, 1'b1);
    rd_chk(RAV, 8'(m + 1));
    pop(m + 1);
    rd_chk(RLS, 8'h01);
    wr_reg(RLS, 8'hff);
    $display("rx packets done");
    wr_reg(hdlc_fifo_pkg::RX_CTL_OFF, 8'h04);
    for (int i = 0; i < 5; i++) begin
      q.push_back(8'($urandom));
      i_eng.push(q[i], 1'b0);
    end
    rd_chk(RRT, 8'h02);
    pop(1);
    rd_chk(RRT, 8'h00);
    rd_chk(RLS, 8'h02);
    pop(4);
    for (int i = 0; i < 65; i++) begin
      if (i == 64) rd_chk(RAV, 8'hc0);
      i_eng.push(8'(i), 1'b0);
    end
    rd_chk(RRT, 8'h21);
    rd_chk(RAV, 8'h00);
    rd_chk(RDAT, 8'h00);
    i_eng.push(8'h99, 1'b1);
    rd_chk(RRT, 8'h01);
    rd_chk(RLS, 8'h22);
    wr_reg(RLS, 8'hff);
    $display("watermark and overrun done");
    wr_reg(hdlc_fifo_pkg::RX_IM_OFF, 8'h01);
    rd_chk(hdlc_fifo_pkg::RX_IM_OFF, 8'h01);
    i_eng.push(8'h3c, 1'b1);
    irq_is(1'b0);
    wr_reg(RLS, 8'h01);
    irq_is(1'b0);
    rd_chk(RLS, 8'h00);
    irq_is(1'b1);
    rd_chk(RDAT, 8'h3c);
    wr_reg(hdlc_fifo_pkg::RX_IM_OFF, 8'h00);
    i_eng.push(8'h11, 1'b1);
    irq_is(1'b1);
    rd_chk(RDAT, 8'h11);
    wr_reg(RLS, 8'hff);
    $display("rx interrupt done");
    wr_reg(hdlc_fifo_pkg::TX_IM_OFF, 8'h02);
    rd_chk(hdlc_fifo_pkg::TX_IM_OFF, 8'h02);
    win = 4'h0;
    wr_reg(hdlc_fifo_pkg::TX_DATA_OFF, 8'h77);
    rd_chk(hdlc_fifo_pkg::TX_SPACE_OFF, 8'h00);
    win = 4'h1;
    rd_chk(hdlc_fifo_pkg::TX_SPACE_OFF, 8'h40);
    tx_run(20 + $urandom % 30);
    // lower tx watermark; the drain must still cross it
    wr_reg(hdlc_fifo_pkg::TX_CTL_OFF, 8'h08);
    rd_chk(hdlc_fifo_pkg::TX_CTL_OFF, 8'h08);
    tx_run(65);
    $display("tx runs done");
    tally_and_finish();
  end
endmodule // hdlc_fifo_status_interrupt_test
bind hdlc_fifo_status_interrupt hdlc_fifo_props #(.FRAMER_INDEX(FRAMER_INDEX)) i_props (
  .clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
  .irq_out_n(irq_out_n), .rx_wr(rx_wr), .rx_byte(rx_byte), .rx_eop(rx_eop), .tx_rd(tx_rd),
  .tx_byte(tx_byte), .tx_last(tx_last), .tx_valid(tx_valid));
`default_nettype wire
